// file: logic/fpsd_defs.vh
// Constants for the floating-point status and move decode block.
`ifndef FPSD_DEFS_VH
`define FPSD_DEFS_VH

// ----------------------------------------------------------------
// Status word field positions
// ----------------------------------------------------------------
`define FPSD_TT_LO 0
`define FPSD_TT_HI 2
`define FPSD_UEN_BIT 3
`define FPSD_UF_BIT 4
`define FPSD_IEN_BIT 5
`define FPSD_IF_BIT 6
`define FPSD_RM_LO 7
`define FPSD_RM_HI 8
`define FPSD_SWF_LO 9
`define FPSD_SWF_HI 15
`define FPSD_RMB_BIT 16
`define FPSD_RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Rounding selections
// ----------------------------------------------------------------
`define FPSD_RM_NEAREST 2'h0
`define FPSD_RM_ZERO 2'h1
`define FPSD_RM_POS 2'h2
`define FPSD_RM_NEG 2'h3

// ----------------------------------------------------------------
// Trap kind codes
// ----------------------------------------------------------------
`define FPSD_TT_NONE 3'h0
`define FPSD_TT_UNDER 3'h1
`define FPSD_TT_OVER 3'h2
`define FPSD_TT_DIVZ 3'h3
`define FPSD_TT_ILLEGAL 3'h4
`define FPSD_TT_INVALID 3'h5
`define FPSD_TT_INEXACT 3'h6

// ----------------------------------------------------------------
// Instruction formats as presented on instr_format
// ----------------------------------------------------------------
`define FPSD_FMT_9 2'h0
`define FPSD_FMT_11 2'h1
`define FPSD_FMT_12 2'h2

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FPSD_OP9_INT2FLT 4'h0
`define FPSD_OP9_LOAD 4'h1
`define FPSD_OP9_D2S 4'h2
`define FPSD_OP9_S2D 4'h3
`define FPSD_OP9_ROUND 4'h4
`define FPSD_OP9_TRUNC 4'h5
`define FPSD_OP9_STORE 4'h6
`define FPSD_OP9_FLOOR 4'h7
`define FPSD_OP11_COPY 4'h1
`define FPSD_OP11_DIV 4'h8

// ----------------------------------------------------------------
// Integer and float type fields
// ----------------------------------------------------------------
`define FPSD_INT_BYTE 2'h0
`define FPSD_INT_WORD 2'h1
`define FPSD_INT_D2S 2'h2
`define FPSD_INT_DWORD 2'h3
`define FPSD_F_SINGLE 1'h1

// ----------------------------------------------------------------
// Decoded operation kinds on op_kind_q
// ----------------------------------------------------------------
`define FPSD_K_NONE 3'h0
`define FPSD_K_COPY 3'h1
`define FPSD_K_D2S 3'h2
`define FPSD_K_S2D 3'h3
`define FPSD_K_I2F 3'h4
`define FPSD_K_F2I 3'h5
`define FPSD_K_ARITH 3'h6
`define FPSD_K_STATUS 3'h7

`endif

// file: logic/fpsd_status.v
// Floating-point status word, exception priority and move/conversion decode.
//
// Summary of operation
// [RQ1] Bits 8:7 pick one of four roundings
// [RQ2] Nearest ties go to even LSB
// [RQ3] Underflow traps if enabled, else positive zero
// [RQ4] Inexact traps if enabled, else rounded result
// [RQ5] Clean non-status instruction zeroes trap kind
// [RQ6] Reset or load of zero clears kind
// [RQ7] Underflow and inexact always recorded in kind
// [RQ8] Kind codes 000 to 110; never 111
// [RQ9] Float or integer overflow reports overflow
// [RQ10] Nonzero/zero divzero; zero/zero or reserved invalid
// [RQ11] Unsupported instruction form reports illegal
// [RQ12] Other exception beats inexact; inexact flag kept
// [RQ13] Sticky underflow set always; load or reset clears
// [RQ14] Sticky inexact only when alone; load clears
// [RQ15] Data register write sets modified flag
// [RQ16] Scratch bits stored and returned only
// [RQ17] Integer field: byte, word, double word
// [RQ18] Float bit one single, zero double
// [RQ19] Plain copy: no conversion, no exceptions
// [RQ20] Double-single, single-double, integer-float conversions
// [RQ21] Nearest, toward zero, floor integer conversions
// [RQ22] Precision conversions need matching type fields
// [RQ23] Reset aborts work, clears whole status word
// [RQ24] Trapped instruction delivers no result
// [RQ25] Bits 31:17 read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "fpsd_defs.vh"

module fpsd_status (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Instruction completion from the datapath
    input wire instr_valid,
    input wire [1:0] instr_format,
    input wire [3:0] instr_op,
    input wire [1:0] instr_int_type,
    input wire instr_float_single,
    input wire dest_is_fp_reg,
    // Conditions raised by the datapath for this instruction
    input wire cond_underflow,
    input wire cond_overflow,
    input wire cond_inexact,
    input wire cond_reserved_operand,
    input wire cond_divisor_zero,
    input wire cond_dividend_zero,
    // Rounding request for the current instruction
    input wire rnd_valid,
    input wire rnd_sign,
    input wire rnd_lsb,
    input wire rnd_guard,
    input wire rnd_sticky,
    // Status load and store operations
    input wire status_load_op,
    input wire [31:0] status_load_data,
    input wire status_store_op,
    // Results
    output reg done_q,
    output reg trap_req_q,
    output reg [2:0] trap_kind_q,
    output reg deliver_result_q,
    output reg force_pos_zero_q,
    output reg regs_write_q,
    output reg round_up_q,
    output reg round_valid_q,
    // Decode
    output reg [2:0] op_kind_q,
    output reg [1:0] int_type_q,
    output reg float_single_q,
    // Status word
    output reg [1:0] rounding_select_q,
    output reg [31:0] float_status_control_q,
    output reg store_valid_q,
    output reg [31:0] store_data_q
);

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    reg [2:0] trap_kind_code_q;
    reg underflow_trap_enable_q;
    reg underflow_sticky_q;
    reg inexact_trap_enable_q;
    reg inexact_sticky_q;
    reg [6:0] software_scratch_bits_q;
    reg regs_modified_flag_q;

    wire [31:0] status_word;
    assign status_word = {15'h0000, regs_modified_flag_q, software_scratch_bits_q,
                          rounding_select_q, inexact_sticky_q, inexact_trap_enable_q,
                          underflow_sticky_q, underflow_trap_enable_q,
                          trap_kind_code_q}; // RQ25

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    reg [2:0] kind_d;
    reg legal_d;
    reg is_div_d;
    reg is_status_d;
    reg [1:0] forced_rm_d;
    reg force_rm_d;

    always @* begin
        kind_d = `FPSD_K_NONE;
        legal_d = 1'b0;
        is_div_d = 1'b0;
        is_status_d = 1'b0;
        forced_rm_d = `FPSD_RM_NEAREST;
        force_rm_d = 1'b0;
        case (instr_format)
            `FPSD_FMT_9: begin
                case (instr_op)
                    `FPSD_OP9_LOAD, `FPSD_OP9_STORE: begin
                        kind_d = `FPSD_K_STATUS;
                        legal_d = 1'b1;
                        is_status_d = 1'b1;
                    end
                    `FPSD_OP9_D2S: begin
                        kind_d = `FPSD_K_D2S; // RQ20
                        legal_d = (instr_float_single == `FPSD_F_SINGLE)
                                  && (instr_int_type == `FPSD_INT_D2S); // RQ22
                    end
                    `FPSD_OP9_S2D: begin
                        kind_d = `FPSD_K_S2D; // RQ20
                        legal_d = (instr_float_single != `FPSD_F_SINGLE)
                                  && (instr_int_type == `FPSD_INT_DWORD); // RQ22
                    end
                    `FPSD_OP9_INT2FLT: begin
                        kind_d = `FPSD_K_I2F; // RQ20
                        legal_d = (instr_int_type != `FPSD_INT_D2S); // RQ17
                    end
                    `FPSD_OP9_ROUND: begin
                        kind_d = `FPSD_K_F2I;
                        legal_d = (instr_int_type != `FPSD_INT_D2S);
                        force_rm_d = 1'b1;
                        forced_rm_d = `FPSD_RM_NEAREST; // RQ21
                    end
                    `FPSD_OP9_TRUNC: begin
                        kind_d = `FPSD_K_F2I;
                        legal_d = (instr_int_type != `FPSD_INT_D2S);
                        force_rm_d = 1'b1;
                        forced_rm_d = `FPSD_RM_ZERO; // RQ21
                    end
                    `FPSD_OP9_FLOOR: begin
                        kind_d = `FPSD_K_F2I;
                        legal_d = (instr_int_type != `FPSD_INT_D2S);
                        force_rm_d = 1'b1;
                        forced_rm_d = `FPSD_RM_NEG; // RQ21
                    end
                    default: legal_d = 1'b0;
                endcase
            end
            `FPSD_FMT_11: begin
                case (instr_op)
                    `FPSD_OP11_COPY: begin
                        kind_d = `FPSD_K_COPY; // RQ19
                        legal_d = 1'b1;
                    end
                    `FPSD_OP11_DIV: begin
                        kind_d = `FPSD_K_ARITH;
                        legal_d = 1'b1;
                        is_div_d = 1'b1;
                    end
                    4'h0, 4'h2, 4'h4, 4'h5, 4'hC, 4'hD: begin
                        kind_d = `FPSD_K_ARITH;
                        legal_d = 1'b1;
                    end
                    default: legal_d = 1'b0;
                endcase
            end
            `FPSD_FMT_12: begin
                case (instr_op)
                    4'h2, 4'h3, 4'h4, 4'h5: begin
                        kind_d = `FPSD_K_ARITH;
                        legal_d = 1'b1;
                    end
                    default: legal_d = 1'b0;
                endcase
            end
            default: legal_d = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Exception priority
    // ----------------------------------------------------------------
    // Higher-severity codes are checked first so that a lone inexact is
    // the only case in which the inexact code can reach the status word.
    reg [2:0] code_d;
    reg trap_d;
    reg other_exc_d;
    reg set_uf_d;
    reg set_if_d;

    always @* begin
        code_d = `FPSD_TT_NONE;
        trap_d = 1'b0;
        other_exc_d = 1'b1;
        set_uf_d = 1'b0;
        set_if_d = 1'b0;
        if (!legal_d) begin
            code_d = `FPSD_TT_ILLEGAL; // RQ11
            trap_d = 1'b1;
        end else if (kind_d == `FPSD_K_COPY) begin
            other_exc_d = 1'b0; // RQ19
        end else if (cond_reserved_operand
                     || (is_div_d && cond_divisor_zero && cond_dividend_zero)) begin
            code_d = `FPSD_TT_INVALID; // RQ10
            trap_d = 1'b1;
        end else if (is_div_d && cond_divisor_zero) begin
            code_d = `FPSD_TT_DIVZ; // RQ10
            trap_d = 1'b1;
        end else if (cond_overflow) begin
            code_d = `FPSD_TT_OVER; // RQ9
            trap_d = 1'b1;
        end else if (cond_underflow) begin
            code_d = `FPSD_TT_UNDER; // RQ7
            trap_d = underflow_trap_enable_q; // RQ3
            set_uf_d = 1'b1; // RQ13
        end else if (cond_inexact) begin // RQ12
            code_d = `FPSD_TT_INEXACT; // RQ7
            trap_d = inexact_trap_enable_q; // RQ4
            set_if_d = 1'b1; // RQ14
            other_exc_d = 1'b0;
        end else begin
            other_exc_d = 1'b0;
        end
        if (other_exc_d && cond_underflow && legal_d && kind_d != `FPSD_K_COPY) begin
            set_uf_d = 1'b1; // RQ13
        end
    end

    // ----------------------------------------------------------------
    // Rounding decision
    // ----------------------------------------------------------------
    wire [1:0] eff_rm;
    assign eff_rm = force_rm_d ? forced_rm_d : rounding_select_q;

    reg up_d;
    always @* begin
        case (eff_rm)
            `FPSD_RM_NEAREST: up_d = rnd_guard & (rnd_sticky | rnd_lsb); // RQ2
            `FPSD_RM_ZERO: up_d = 1'b0; // RQ1
            `FPSD_RM_POS: up_d = ~rnd_sign & (rnd_guard | rnd_sticky); // RQ1
            `FPSD_RM_NEG: up_d = rnd_sign & (rnd_guard | rnd_sticky); // RQ1
            default: up_d = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    wire run_op;
    assign run_op = instr_valid && !is_status_d;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            trap_kind_code_q <= `FPSD_TT_NONE; // RQ6
            underflow_trap_enable_q <= 1'b0; // RQ23
            underflow_sticky_q <= 1'b0;
            inexact_trap_enable_q <= 1'b0;
            inexact_sticky_q <= 1'b0;
            rounding_select_q <= `FPSD_RM_NEAREST;
            software_scratch_bits_q <= 7'h00;
            regs_modified_flag_q <= 1'b0;
            done_q <= 1'b0;
            trap_req_q <= 1'b0;
            trap_kind_q <= `FPSD_TT_NONE;
            deliver_result_q <= 1'b0;
            force_pos_zero_q <= 1'b0;
            regs_write_q <= 1'b0;
            round_up_q <= 1'b0;
            round_valid_q <= 1'b0;
            op_kind_q <= `FPSD_K_NONE;
            int_type_q <= `FPSD_INT_BYTE;
            float_single_q <= 1'b0;
            float_status_control_q <= `FPSD_RESET_WORD;
            store_valid_q <= 1'b0;
            store_data_q <= `FPSD_RESET_WORD;
        end else begin
            done_q <= run_op;
            trap_req_q <= run_op && trap_d;
            deliver_result_q <= run_op && !trap_d; // RQ24
            regs_write_q <= run_op && !trap_d && dest_is_fp_reg; // RQ24
            force_pos_zero_q <= run_op && !trap_d
                                && code_d == `FPSD_TT_UNDER; // RQ3
            round_valid_q <= rnd_valid;
            round_up_q <= rnd_valid && up_d;
            if (instr_valid) begin
                op_kind_q <= kind_d;
                int_type_q <= instr_int_type; // RQ17
                float_single_q <= instr_float_single; // RQ18
            end
            if (run_op) begin
                trap_kind_q <= code_d; // RQ8
            end
            // A load rewrites every writable field; hardware events that land
            // in the same cycle are ORed into the sticky and modified flags only;
            // the trap kind of a same-cycle instruction is lost to the loaded value.
            if (status_load_op) begin
                trap_kind_code_q <= status_load_data[`FPSD_TT_HI:`FPSD_TT_LO]; // RQ6
                underflow_trap_enable_q <= status_load_data[`FPSD_UEN_BIT];
                inexact_trap_enable_q <= status_load_data[`FPSD_IEN_BIT];
                rounding_select_q <= status_load_data[`FPSD_RM_HI:`FPSD_RM_LO];
                software_scratch_bits_q <=
                    status_load_data[`FPSD_SWF_HI:`FPSD_SWF_LO]; // RQ16
            end else if (run_op) begin
                trap_kind_code_q <= code_d; // RQ5
            end
            underflow_sticky_q <= (status_load_op ? status_load_data[`FPSD_UF_BIT]
                                   : underflow_sticky_q)
                                  | (run_op && set_uf_d); // RQ13
            inexact_sticky_q <= (status_load_op ? status_load_data[`FPSD_IF_BIT]
                                 : inexact_sticky_q)
                                | (run_op && set_if_d && !other_exc_d); // RQ14
            regs_modified_flag_q <= (status_load_op ? status_load_data[`FPSD_RMB_BIT]
                                     : regs_modified_flag_q)
                                    | (run_op && !trap_d && dest_is_fp_reg); // RQ15
            float_status_control_q <= status_word;
            store_valid_q <= status_store_op;
            if (status_store_op) begin
                store_data_q <= status_word; // RQ16
            end
        end
    end

endmodule // fpsd_status
`default_nettype wire

// file: tb/fpsd_host.sv
// Host model that issues status load and status store requests.
`timescale 1ns/1ps
`default_nettype none
module fpsd_host (
    // Clock
    input wire logic sys_clk,
    // Status port of the block
    output logic status_load_op,
    output logic [31:0] status_load_data,
    output logic status_store_op,
    input wire logic store_valid_q,
    input wire logic [31:0] store_data_q
);
    initial begin
        status_load_op = 1'b0;
        status_load_data = 32'h0;
        status_store_op = 1'b0;
    end
    // Both tasks are entered just after a falling edge.
    task automatic load(input logic [31:0] d);
        status_load_op = 1'b1;
        status_load_data = d;
        @(negedge sys_clk);
        status_load_op = 1'b0;
        // A released bus must not keep showing the last word.
        status_load_data = ~d;
    endtask
    task automatic store(output logic v, output logic [31:0] d);
        status_store_op = 1'b1;
        @(negedge sys_clk);
        status_store_op = 1'b0;
        v = store_valid_q;
        d = store_data_q;
    endtask
endmodule // fpsd_host
`default_nettype wire

// file: tb/fpsd_status_assertions.sv
// Concurrent checks on the ports of the status block.
`timescale 1ns/1ps
`default_nettype none
module fpsd_status_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Requests
    input wire logic instr_valid,
    input wire logic [1:0] instr_format,
    input wire logic [3:0] instr_op,
    input wire logic status_load_op,
    input wire logic [31:0] status_load_data,
    input wire logic status_store_op,
    // Answers
    input wire logic done_q,
    input wire logic trap_req_q,
    input wire logic [2:0] trap_kind_q,
    input wire logic deliver_result_q,
    input wire logic regs_write_q,
    input wire logic force_pos_zero_q,
    input wire logic [1:0] rounding_select_q,
    input wire logic [31:0] float_status_control_q,
    input wire logic store_valid_q,
    input wire logic [31:0] store_data_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic st_op = instr_format == 2'h0 && (instr_op == 4'h1 || instr_op == 4'h6);
    instr_done_a: assert property (instr_valid && !st_op |=> done_q)
        else $error("No done pulse after an instruction.");
    kind_legal_a: assert property (done_q |-> trap_kind_q != 3'h7)
        else $error("Reserved trap code produced.");
    no_result_a: assert property (trap_req_q |-> !deliver_result_q && !regs_write_q)
        else $error("Trapped instruction delivered a result.");
    illegal_trap_a: assert property (instr_valid && instr_format == 2'h3 && !status_load_op
        |=> trap_req_q && trap_kind_q == 3'h4)
        else $error("Illegal form not trapped.");
    copy_clean_a: assert property (instr_valid && instr_format == 2'h1 && instr_op == 4'h1
        |=> !trap_req_q && trap_kind_q == 3'h0)
        else $error("Plain copy raised an exception.");
    uf_sticky_a: assert property (done_q && trap_kind_q == 3'h1
        |=> float_status_control_q[4])
        else $error("Underflow flag not set.");
    rmb_set_a: assert property (regs_write_q |=> float_status_control_q[16])
        else $error("Modified flag not set.");
    rsel_lag_a: assert property (float_status_control_q[8:7] == $past(rounding_select_q))
        else $error("Rounding field mismatch.");
    load_rsel_a: assert property (status_load_op
        |=> rounding_select_q == $past(status_load_data[8:7]))
        else $error("Load did not set rounding.");
    store_resv_a: assert property (status_store_op
        |=> store_valid_q && store_data_q[31:17] == 15'h0)
        else $error("Store answer wrong.");
    trap_seen_c: cover property (trap_req_q);
    pos_zero_c: cover property (force_pos_zero_q);
    store_seen_c: cover property (store_valid_q);
endmodule // fpsd_status_assertions
bind fpsd_status fpsd_status_assertions i_chk (.sys_clk, .rst_n, .instr_valid, .instr_format,
    .instr_op, .status_load_op, .status_load_data, .status_store_op, .done_q, .trap_req_q,
    .trap_kind_q, .deliver_result_q, .regs_write_q, .force_pos_zero_q, .rounding_select_q,
    .float_status_control_q, .store_valid_q, .store_data_q);
`default_nettype wire

// file: tb/fpsd_status_bench.sv
// Self-checking bench for the status block against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
module fp_status_and_move_decode_bench;
    logic sys_clk, rst_n, instr_valid, instr_float_single, dest_is_fp_reg;
    logic [1:0] instr_format, instr_int_type;
    logic [3:0] instr_op;
    logic cond_underflow, cond_overflow, cond_inexact, cond_reserved_operand;
    logic cond_divisor_zero, cond_dividend_zero, rnd_valid, rnd_sign, rnd_lsb;
    logic rnd_guard, rnd_sticky, status_load_op, status_store_op;
    logic [31:0] status_load_data, float_status_control_q, store_data_q;
    logic done_q, trap_req_q, deliver_result_q, force_pos_zero_q, regs_write_q;
    logic round_up_q, round_valid_q, float_single_q, store_valid_q;
    logic [2:0] trap_kind_q, op_kind_q;
    logic [1:0] int_type_q, rounding_select_q;
    int seed = 70723;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] m, d;
    logic [1:0] fmt, it, rm;
    logic [3:0] op;
    logic [2:0] kd, ok;
    logic f, lg, cp, tp, up, v;

    fpsd_status i_dut (.sys_clk, .rst_n, .instr_valid, .instr_format, .instr_op,
        .instr_int_type, .instr_float_single, .dest_is_fp_reg, .cond_underflow,
        .cond_overflow, .cond_inexact, .cond_reserved_operand, .cond_divisor_zero,
        .cond_dividend_zero, .rnd_valid, .rnd_sign, .rnd_lsb, .rnd_guard, .rnd_sticky,
        .status_load_op, .status_load_data, .status_store_op, .done_q, .trap_req_q,
        .trap_kind_q, .deliver_result_q, .force_pos_zero_q, .regs_write_q, .round_up_q,
        .round_valid_q, .op_kind_q, .int_type_q, .float_single_q, .rounding_select_q,
        .float_status_control_q, .store_valid_q, .store_data_q);
    fpsd_host i_host (.sys_clk, .status_load_op, .status_load_data, .status_store_op,
        .store_valid_q, .store_data_q);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {rst_n, instr_valid, instr_format, instr_op, instr_int_type, instr_float_single} = 0;
        {dest_is_fp_reg, cond_underflow, cond_overflow, cond_inexact} = 4'h0;
        {cond_reserved_operand, cond_divisor_zero, cond_dividend_zero, rnd_valid} = 4'h0;
        {rnd_sign, rnd_lsb, rnd_guard, rnd_sticky} = 4'h0;
        m = 32'h0;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 400; i++) begin
            if (i == 200) begin
                // A mid-run reset must wipe the whole status word.
                rst_n = 1'b0;
                repeat (2) @(negedge sys_clk);
                rst_n = 1'b1;
                m = 32'h0;
                i_host.store(v, d);
                chk("rstword", d, 32'h0);
                chk("rstkind", 32'({done_q, trap_kind_q}), 32'h0);
            end
            if (i % 8 == 0) begin
                d = (i % 32 == 16) ? 32'h0 : $random(seed);
                i_host.load(d);
                m = d & 32'h0001_FFFF;
                chk("rsel", 32'(rounding_select_q), 32'(d[8:7]));
            end
            d = $random(seed);
            fmt = d[1:0];
            op = (fmt == 2'h0) ? {1'b0, d[4:2]} : d[5:2];
            if (fmt == 2'h0 && (op == 4'h1 || op == 4'h6))
                op = op + 4'h1;
            it = d[7:6];
            f = d[8];
            case (fmt)
                2'h0: case (op)
                    4'h0, 4'h4, 4'h5, 4'h7: lg = it != 2'h2;
                    4'h2: lg = f && it == 2'h2;
                    4'h3: lg = !f && it == 2'h3;
                    default: lg = 1'b0;
                endcase
                2'h1: lg = op inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'hC, 4'hD};
                2'h2: lg = op inside {[4'h2:4'h5]};
                default: lg = 1'b0;
            endcase
            cp = lg && fmt == 2'h1 && op == 4'h1;
            {cond_underflow, cond_overflow} = {d[11:10] == 2'h0, d[13:12] == 2'h0};
            {cond_inexact, cond_reserved_operand} = {d[15:14] == 2'h0, d[18:16] == 3'h0};
            cond_divisor_zero = d[20:19] == 2'h0 && fmt == 2'h1 && op == 4'h8;
            {cond_dividend_zero, dest_is_fp_reg, rnd_sign, rnd_lsb} = d[24:21];
            {rnd_guard, rnd_sticky} = d[26:25];
            if (!lg || cp)
                {cond_underflow, cond_overflow, cond_inexact, cond_divisor_zero} = 4'h0;
            if (!lg)
                cond_reserved_operand = 1'b0;
            if (!lg) kd = 3'h4;
            else if (cp) kd = 3'h0;
            else if (cond_reserved_operand || (cond_divisor_zero && cond_dividend_zero))
                kd = 3'h5;
            else if (cond_divisor_zero) kd = 3'h3;
            else if (cond_overflow) kd = 3'h2;
            else if (cond_underflow) kd = 3'h1;
            else if (cond_inexact) kd = 3'h6;
            else kd = 3'h0;
            tp = kd inside {[3'h2:3'h5]} || (kd == 3'h1 && m[3]) || (kd == 3'h6 && m[5]);
            rm = (fmt == 2'h0 && op inside {4'h4, 4'h5, 4'h7}) ?
                ((op == 4'h4) ? 2'h0 : (op == 4'h5) ? 2'h1 : 2'h3) : m[8:7];
            case (rm)
                2'h0: up = rnd_guard & (rnd_sticky | rnd_lsb);
                2'h1: up = 1'b0;
                2'h2: up = (rnd_guard | rnd_sticky) & !rnd_sign;
                default: up = (rnd_guard | rnd_sticky) & rnd_sign;
            endcase
            ok = (fmt != 2'h0) ? (cp ? 3'h1 : 3'h6) : (op == 4'h0) ? 3'h4 :
                (op == 4'h2) ? 3'h2 : (op == 4'h3) ? 3'h3 : 3'h5;
            {instr_format, instr_op, instr_int_type, instr_float_single} = {fmt, op, it, f};
            {instr_valid, rnd_valid} = 2'h3;
            @(negedge sys_clk);
            {instr_valid, rnd_valid} = 2'h0;
            chk("result", 32'({done_q, trap_req_q, trap_kind_q, deliver_result_q,
                regs_write_q, force_pos_zero_q}), 32'({1'b1, tp, kd, !tp,
                dest_is_fp_reg && !tp, kd == 3'h1 && !m[3]}));
            chk("round", 32'({round_valid_q, round_up_q}), 32'({1'b1, up}));
            chk("types", 32'({int_type_q, float_single_q}), 32'({it, f}));
            if (lg)
                chk("opkind", 32'(op_kind_q), 32'(ok));
            m[2:0] = kd;
            if (cond_underflow) m[4] = 1'b1;
            if (kd == 3'h6) m[6] = 1'b1;
            if (dest_is_fp_reg && !tp) m[16] = 1'b1;
            i_host.store(v, d);
            chk("stvalid", 32'(v), 32'h1);
            chk("word", d, m);
            chk("status", float_status_control_q, m);
        end
        end_of_test();
    end
endmodule // fp_status_and_move_decode_bench
`default_nettype wire
